// *** inc/rsre_defs.svh ***
`ifndef RSRE_DEFS_SVH
`define RSRE_DEFS_SVH
// byte offsets within the low 10 address bits
`define RSRE_OFF_CMD 10'h000
`define RSRE_OFF_ACC 10'h004
`define RSRE_OFF_STAT 10'h008
`define RSRE_OFF_PC 10'h00c
`define RSRE_OFF_STK 10'h010
`define RSRE_OFF_WDT 10'h014
// address bit that selects the file register window
`define RSRE_FILE_BIT 9
// command word fields
`define RSRE_CMD_OP 2:0
`define RSRE_CMD_DEST 3
`define RSRE_CMD_OMIT 4
`define RSRE_CMD_ADDR 14:8
`define RSRE_CMD_LIT 23:16
// status word bits
`define RSRE_ST_BORROW 0
`define RSRE_ST_NIB 1
`define RSRE_ST_ZERO 2
`define RSRE_ST_TMO 3
`define RSRE_ST_PD 4
`define RSRE_ST_RI 5
`define RSRE_ST_BUSY 6
// reset values
`define RSRE_ACC_RST 8'h00
`define RSRE_FLAG_RST 1'b0
`define RSRE_TMO_RST 1'b1
`define RSRE_PD_RST 1'b1
`define RSRE_RI_RST 1'b1
// bus answers
`define RSRE_RESP_OK 2'b00
`define RSRE_RESP_ERR 2'b10
`endif

// *** inc/rsre_pkg.sv ***
package rsre_pkg;
   typedef enum logic [2:0] {
      OP_RET, OP_ROTL, OP_ROTR, OP_SLEEP, OP_SUBL, OP_SUBF, OP_RST
   } rsre_op_t;
   typedef enum logic {ST_IDLE, ST_RET2} rsre_state_t;
endpackage : rsre_pkg

// *** design/rsre_exec.sv ***
`timescale 1ns/10ps
`include "rsre_defs.svh"
module rsre_exec
   import rsre_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int STK_DEPTH = 16,
   parameter int PC_W = 15
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int SP_W = $clog2(STK_DEPTH);

   if (ADDR_W < 11 || STK_DEPTH < 2 || (1 << SP_W) != STK_DEPTH || PC_W < 8 || PC_W > 16)
   begin : g_check
      $error("rsre_exec: unsupported parameter values");
   end

   logic aw_have, next_aw_have, w_have, next_w_have;
   logic [ADDR_W-1:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic [7:0] acc, next_acc;
   logic borrow, next_borrow, nib, next_nib, zero, next_zero;
   logic tmo, next_tmo, pd, next_pd, ri, next_ri;
   logic [PC_W-1:0] pc, next_pc;
   logic [SP_W-1:0] sp, next_sp;
   logic [31:0] cmd, next_cmd;
   logic go, next_go;
   rsre_state_t state, next_state;
   logic [7:0] wdt, next_wdt, pre, next_pre;
   logic [7:0] fregs [128];
   logic [PC_W-1:0] stk [STK_DEPTH];
   logic mem_we, stk_we;
   logic [6:0] mem_wa;
   logic [7:0] mem_wd;
   logic [SP_W-1:0] stk_wa;
   logic [PC_W-1:0] stk_wd;
   logic busy, dst_f, hit_w, hit_r;
   logic [7:0] opnd, res;
   logic [PC_W-1:0] stack_top_entry;
   logic [9:0] woff, roff;
   rsre_op_t op;

   assign busy = go || (state == ST_RET2);
   assign stack_top_entry = stk[sp];
   assign op = rsre_op_t'(cmd[`RSRE_CMD_OP]);
   assign opnd = fregs[cmd[`RSRE_CMD_ADDR]];
   assign dst_f = cmd[`RSRE_CMD_DEST] | cmd[`RSRE_CMD_OMIT];
   assign woff = aw_addr[9:0];
   assign roff = s_axi_araddr[9:0];
   assign hit_w = (aw_addr[ADDR_W-1:10] == '0);
   assign hit_r = (s_axi_araddr[ADDR_W-1:10] == '0);

   always_comb begin
      next_aw_have = aw_have;
      next_aw_addr = aw_addr;
      next_w_have = w_have;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid;
      next_rresp = s_axi_rresp;
      next_rdata = s_axi_rdata;
      next_acc = acc;
      next_borrow = borrow;
      next_nib = nib;
      next_zero = zero;
      next_tmo = tmo;
      next_pd = pd;
      next_ri = ri;
      next_pc = pc;
      next_sp = sp;
      next_cmd = cmd;
      next_go = 1'b0;
      next_state = ST_IDLE;
      next_pre = pre + 8'h01;
      next_wdt = (pre == 8'hff) ? wdt + 8'h01 : wdt;
      mem_we = 1'b0;
      mem_wa = woff[8:2];
      mem_wd = w_data[7:0];
      stk_we = 1'b0;
      stk_wa = sp + 1'b1;
      stk_wd = w_data[PC_W-1:0];
      res = 8'h00;
      // write channel
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_have = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_have = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (aw_have && w_have && !s_axi_bvalid) begin
         next_aw_have = 1'b0;
         next_w_have = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = `RSRE_RESP_OK;
         if (!hit_w) begin
            next_bresp = `RSRE_RESP_ERR;
         end else if (woff[`RSRE_FILE_BIT]) begin
            mem_we = w_strb[0];
         end else if (woff == `RSRE_OFF_CMD) begin
            // a command while one is still running is dropped
            if (!busy) begin
               next_cmd = w_data;
               next_go = 1'b1;
            end
         end else if (woff == `RSRE_OFF_ACC) begin
            if (w_strb[0]) begin
               next_acc = w_data[7:0];
            end
         end else if (woff == `RSRE_OFF_STAT) begin
            if (w_strb[0]) begin
               next_borrow = w_data[`RSRE_ST_BORROW];
               next_nib = w_data[`RSRE_ST_NIB];
               next_zero = w_data[`RSRE_ST_ZERO];
               next_tmo = w_data[`RSRE_ST_TMO];
               next_pd = w_data[`RSRE_ST_PD];
               next_ri = w_data[`RSRE_ST_RI];
            end
         end else if (woff == `RSRE_OFF_PC) begin
            if (w_strb[0]) begin
               next_pc = w_data[PC_W-1:0];
            end
         end else if (woff == `RSRE_OFF_STK) begin
            stk_we = 1'b1;
            next_sp = sp + 1'b1;
         end else if (woff != `RSRE_OFF_WDT) begin
            next_bresp = `RSRE_RESP_ERR;
         end
      end
      next_awready = !next_aw_have;
      next_wready = !next_w_have;
      // read channel
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp = `RSRE_RESP_OK;
         next_rdata = 32'h00000000;
         if (!hit_r) begin
            next_rresp = `RSRE_RESP_ERR;
         end else if (roff[`RSRE_FILE_BIT]) begin
            next_rdata[7:0] = fregs[roff[8:2]];
         end else if (roff == `RSRE_OFF_CMD) begin
            next_rdata = cmd;
         end else if (roff == `RSRE_OFF_ACC) begin
            next_rdata[7:0] = acc;
         end else if (roff == `RSRE_OFF_STAT) begin
            next_rdata[6:0] = {busy, ri, pd, tmo, zero, nib, borrow};
         end else if (roff == `RSRE_OFF_PC) begin
            next_rdata[PC_W-1:0] = pc;
         end else if (roff == `RSRE_OFF_STK) begin
            next_rdata[PC_W-1:0] = stack_top_entry;
         end else if (roff == `RSRE_OFF_WDT) begin
            next_rdata[15:0] = {pre, wdt};
         end else begin
            next_rresp = `RSRE_RESP_ERR;
         end
      end
      next_arready = !next_rvalid;
      // execution: one cycle after the command word lands
      if (go) begin
         next_pc = pc + 1'b1;
         unique case (op)
            OP_RET: begin
               next_pc = stack_top_entry;
               next_sp = sp - 1'b1;
               next_state = ST_RET2;
            end
            OP_ROTL, OP_ROTR: begin
               if (op == OP_ROTL) begin
                  res = {opnd[6:0], borrow};
                  next_borrow = opnd[7];
               end else begin
                  res = {borrow, opnd[7:1]};
                  next_borrow = opnd[0];
               end
            end
            OP_SLEEP: begin
               next_wdt = 8'h00;
               next_pre = 8'h00;
               next_pd = 1'b0;
               next_tmo = 1'b1;
            end
            OP_SUBL: begin
               res = cmd[`RSRE_CMD_LIT] - acc;
               next_acc = res;
               next_borrow = (acc <= cmd[`RSRE_CMD_LIT]);
               next_nib = (acc[3:0] <= cmd[19:16]);
               next_zero = (res == 8'h00);
            end
            OP_SUBF: begin
               res = opnd - acc;
               next_borrow = (acc <= opnd);
               next_nib = (acc[3:0] <= opnd[3:0]);
               next_zero = (res == 8'h00);
            end
            OP_RST: begin
               next_ri = 1'b0;
               next_pc = '0;
               next_sp = '0;
            end
            default: begin
            end
         endcase
         if (op == OP_ROTL || op == OP_ROTR || op == OP_SUBF) begin
            if (dst_f) begin
               mem_we = 1'b1;
               mem_wa = cmd[`RSRE_CMD_ADDR];
               mem_wd = res;
            end else begin
               next_acc = res;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have <= 1'b0;
         aw_addr <= '0;
         w_have <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RSRE_RESP_OK;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `RSRE_RESP_OK;
         s_axi_rdata <= 32'h00000000;
         acc <= `RSRE_ACC_RST;
         borrow <= `RSRE_FLAG_RST;
         nib <= `RSRE_FLAG_RST;
         zero <= `RSRE_FLAG_RST;
         tmo <= `RSRE_TMO_RST;
         pd <= `RSRE_PD_RST;
         ri <= `RSRE_RI_RST;
         pc <= '0;
         sp <= '0;
         cmd <= 32'h00000000;
         go <= 1'b0;
         state <= ST_IDLE;
         wdt <= 8'h00;
         pre <= 8'h00;
      end else begin
         aw_have <= next_aw_have;
         aw_addr <= next_aw_addr;
         w_have <= next_w_have;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp <= next_rresp;
         s_axi_rdata <= next_rdata;
         acc <= next_acc;
         borrow <= next_borrow;
         nib <= next_nib;
         zero <= next_zero;
         tmo <= next_tmo;
         pd <= next_pd;
         ri <= next_ri;
         pc <= next_pc;
         sp <= next_sp;
         cmd <= next_cmd;
         go <= next_go;
         state <= next_state;
         wdt <= next_wdt;
         pre <= next_pre;
      end
   end

   always_ff @(posedge aclk) begin
      if (mem_we) begin
         fregs[mem_wa] <= mem_wd;
      end
      if (stk_we) begin
         stk[stk_wa] <= stk_wd;
      end
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_ret_pc_load: assert property (go && op == OP_RET |=> pc == $past(stack_top_entry) && sp == $past(sp) - 1'b1)
      else $error("return did not load pc from stack top");
   a_ret_two_cyc: assert property (go && op == OP_RET |=> busy ##1 !busy)
      else $error("return not exactly two cycles");
   a_rotl_shift: assert property (go && op == OP_ROTL && !dst_f |=>
      acc == {$past(opnd[6:0]), $past(borrow)} && borrow == $past(opnd[7]))
      else $error("rotate left wrong");
   a_rotr_shift: assert property (go && op == OP_ROTR && !dst_f |=>
      acc == {$past(borrow), $past(opnd[7:1])} && borrow == $past(opnd[0]))
      else $error("rotate right wrong");
   a_dest_file: assert property (go && op == OP_SUBF && dst_f |=> $stable(acc))
      else $error("file destination touched accumulator");
   a_dest_omit: assert property (
      go && (op == OP_ROTL || op == OP_ROTR) && cmd[`RSRE_CMD_OMIT] |-> mem_we)
      else $error("omitted destination not stored to file");
   a_sleep_wdt: assert property (go && op == OP_SLEEP |=> wdt == 8'h00 && pre == 8'h00)
      else $error("sleep did not clear watchdog");
   a_sleep_flags: assert property (go && op == OP_SLEEP |=> !pd && tmo)
      else $error("sleep status bits wrong");
   a_subl_result: assert property (go && op == OP_SUBL |=>
      acc == $past(cmd[23:16]) - $past(acc))
      else $error("literal subtract result wrong");
   a_subl_borrow: assert property (go && op == OP_SUBL |=>
      borrow == ($past(acc) <= $past(cmd[23:16]))
      && nib == ($past(acc[3:0]) <= $past(cmd[19:16])))
      else $error("literal subtract borrows wrong");
   a_subf_borrow: assert property (go && op == OP_SUBF |=>
      borrow == ($past(acc) <= $past(opnd)) && nib == ($past(acc[3:0]) <= $past(opnd[3:0])))
      else $error("file subtract borrows wrong");
   a_rot_flags: assert property (go && (op == OP_ROTL || op == OP_ROTR) |=>
      $stable(zero) && $stable(nib))
      else $error("rotate changed other flags");
   a_zero_flag: assert property (go && op == OP_SUBL |=> zero == (acc == 8'h00) && !busy)
      else $error("zero flag wrong");
   a_rst_flag: assert property (go && op == OP_RST |=> !ri)
      else $error("reset indicator not cleared");

   c_ret: cover property (go && op == OP_RET ##2 !busy);
   c_subl_zero: cover property (go && op == OP_SUBL ##1 zero);
   c_sleep: cover property (go && op == OP_SLEEP);
   c_rot_file: cover property (go && op == OP_ROTR && dst_f);
endmodule : rsre_exec

// *** verification/testbench.sv ***
`timescale 1ns/10ps
`include "rsre_defs.svh"
module testbench;
   import rsre_pkg::*;
   logic aclk, aresetn;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r, r2;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] d;
   logic [7:0] res;
   int err_count, samples_checked, cycles;
   localparam logic [11:0] CMD = {2'b00, `RSRE_OFF_CMD};
   localparam logic [11:0] ACC = {2'b00, `RSRE_OFF_ACC};
   localparam logic [11:0] STAT = {2'b00, `RSRE_OFF_STAT};
   localparam logic [11:0] PC = {2'b00, `RSRE_OFF_PC};
   localparam logic [11:0] STK = {2'b00, `RSRE_OFF_STK};
   localparam logic [11:0] WDT = {2'b00, `RSRE_OFF_WDT};
   logic [7:0] va[4] = '{8'h05, 8'h06, 8'h10, 8'h01};
   logic [7:0] vk[4] = '{8'h05, 8'h05, 8'h0f, 8'h10};

   rsre_exec u_rsre_exec (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim

   // a hang in any handshake ends the run here
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         end_sim();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // each valid drops at the edge that takes it; the answer is taken at its own edge
   task wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
         end
         if (s_axi_bvalid) begin
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask : wr

   task rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
         end
         if (s_axi_rvalid) begin
            v = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask : rd

   function automatic logic [31:0] cmd(rsre_op_t op, logic dst, logic omit, logic [6:0] fa,
                                       logic [7:0] lit);
      return {8'h00, lit, 1'b0, fa, 3'b000, omit, dst, op};
   endfunction : cmd

   function automatic logic [11:0] fadr(logic [6:0] fa);
      return 12'h200 + {3'b000, fa, 2'b00};
   endfunction : fadr

   task run(input logic [31:0] c);
      wr(CMD, c, r);
      repeat (20) begin
         rd(STAT, d, r);
         if (d[`RSRE_ST_BUSY] === 1'b0) break;
      end
      chk(d[`RSRE_ST_BUSY], 1'b0);
   endtask : run

   initial begin
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(STAT, d, r);
      chk(d, 32'h0000_0038);
      // rotates through the borrow flag
      wr(fadr(7'h05), 32'h0000_00e6, r);
      wr(STAT, 32'h0000_0038, r);
      run(cmd(OP_ROTL, 1'b0, 1'b0, 7'h05, 8'h00));
      rd(ACC, d, r); chk(d, 32'h0000_00cc);
      rd(STAT, d, r); chk(d & 32'h7, 32'h1);
      rd(fadr(7'h05), d, r); chk(d & 32'hff, 32'he6);
      wr(fadr(7'h7f), 32'h0000_0001, r);
      wr(STAT, 32'h0000_003f, r);
      run(cmd(OP_ROTR, 1'b0, 1'b1, 7'h7f, 8'h00));
      rd(fadr(7'h7f), d, r); chk(d & 32'hff, 32'h80);
      rd(ACC, d, r); chk(d, 32'h0000_00cc);
      rd(STAT, d, r); chk(d & 32'h7, 32'h7);
      // both subtract forms over borrow and nibble borrow corners
      for (int i = 0; i < 4; i++) begin
         res = vk[i] - va[i];
         wr(ACC, {24'h0, va[i]}, r);
         run(cmd(OP_SUBL, 1'b0, 1'b0, 7'h00, vk[i]));
         rd(ACC, d, r); chk(d, {24'h0, res});
         rd(STAT, d, r); chk(d & 32'h7, {res == 8'h00, va[i][3:0] <= vk[i][3:0],
            va[i] <= vk[i]});
         wr(fadr(7'h0a), {24'h0, vk[i]}, r);
         wr(ACC, {24'h0, va[i]}, r);
         run(cmd(OP_SUBF, i[0], 1'b0, 7'h0a, 8'h00));
         rd(fadr(7'h0a), d, r); chk(d & 32'hff, i[0] ? res : vk[i]);
         rd(ACC, d, r); chk(d, {24'h0, i[0] ? va[i] : res});
         rd(STAT, d, r); chk(d & 32'h7, {res == 8'h00, va[i][3:0] <= vk[i][3:0],
            va[i] <= vk[i]});
      end
      // return pops in reverse order and stays busy a second cycle
      wr(STK, 32'h0000_0111, r);
      wr(STK, 32'h0000_0222, r);
      fork
         wr(CMD, cmd(OP_RET, 1'b0, 1'b0, 7'h00, 8'h00), r2);
         begin
            // the read is taken at the end of the second cycle of the return
            repeat (3) @(posedge aclk);
            rd(STAT, d, r);
         end
      join
      chk(d[`RSRE_ST_BUSY], 1'b1);
      rd(STAT, d, r); chk(d[`RSRE_ST_BUSY], 1'b0);
      rd(PC, d, r); chk(d, 32'h0000_0222);
      run(cmd(OP_RET, 1'b0, 1'b0, 7'h00, 8'h00));
      rd(PC, d, r); chk(d, 32'h0000_0111);
      // low-power entry after the watchdog has advanced
      repeat (600) @(posedge aclk);
      rd(WDT, d, r); chk(d[7:0] != 8'h00, 1'b1);
      wr(STAT, 32'h0000_0030, r);
      run(cmd(OP_SLEEP, 1'b0, 1'b0, 7'h00, 8'h00));
      rd(STAT, d, r); chk(d[4:3], 2'b01);
      rd(WDT, d, r); chk({d[7:0], d[15:8] < 8'h40}, 9'h001);
      run(cmd(OP_RST, 1'b0, 1'b0, 7'h00, 8'h00));
      rd(STAT, d, r); chk(d[`RSRE_ST_RI], 1'b0);
      rd(PC, d, r); chk(d, 32'h0);
      // unmapped places answer with an error
      rd(12'h018, d, r); chk(d, 32'h0);
      chk({30'h0, r}, {30'h0, `RSRE_RESP_ERR});
      wr(12'h400, 32'h0000_00ff, r); chk(r, `RSRE_RESP_ERR);
      end_sim();
   end
endmodule : testbench
